// >>> thread_qualified_perf_events.sv
// Purpose: Two thread-qualified counters with precise sampling control,
//          clocktick modes and a time-stamp counter.
// Assumes: Register accesses are single-cycle strobes from either thread.
// Notes:   Read data and fault answer one cycle after the strobe.
`timescale 1ns/100ps
`include "perf_qual_regs.svh"
module thread_qualified_perf_events import perf_qual_pkg::*; (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [63:0] reg_wdata_i,
  input wire logic [7:0] reg_initial_id_i,
  output logic [63:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_fault_o,
  // Thread state
  input wire logic dual_thread_i,
  input wire logic [1:0] t0_priv_i,
  input wire logic [1:0] t1_priv_i,
  input wire logic [1:0] halted_i,
  input wire logic [1:0] power_save_i,
  input wire logic package_sleep_i,
  input wire logic deep_sleep_i,
  // Event stream
  input wire logic event_valid_i,
  input wire logic event_thread_i,
  input wire logic thread_independent_event_i,
  input wire logic [1:0] event_class_i,
  // Sampling and interrupt requests
  output logic [1:0] precise_sample_o,
  output logic [1:0] overflow_irq_o
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [63:0] cfg_reg [2];
  logic [`CNT_W-1:0] count_reg [2];
  logic [63:0] tsc_reg;
  logic [1:0] sample_en_reg;
  logic [63:0] rdata_next;
  logic fault_next;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Maps an own/sibling pair onto absolute threads
  function automatic logic [1:0] rel_to_abs(input logic me, input logic own,
                                            input logic sib);
    logic [1:0] r;
    r = 2'h0;
    r[me] = own;
    r[~me] = sib;
    return r;
  endfunction : rel_to_abs

  // True when the counter runs in the given mode
  function automatic logic is_mode(input logic [63:0] cfg, input count_mode_t m);
    return cfg[`CFG_MODE_HI:`CFG_MODE_LO] == m;
  endfunction : is_mode

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire logic writer_thread = reg_initial_id_i[0];
  wire logic hit_cfg0 = (reg_addr_i == `ADDR_T0_CFG);
  wire logic hit_cfg1 = (reg_addr_i == `ADDR_T1_CFG);
  wire logic hit_sen = (reg_addr_i == `ADDR_SAMPLE_EN);
  wire logic hit_cnt0 = (reg_addr_i == `ADDR_T0_COUNT);
  wire logic hit_cnt1 = (reg_addr_i == `ADDR_T1_COUNT);
  wire logic hit_tsc = (reg_addr_i == `ADDR_TSC);
  wire logic hit_any = hit_cfg0 | hit_cfg1 | hit_sen | hit_cnt0 | hit_cnt1 | hit_tsc;
  wire logic [1:0] wr_cfg = {2{reg_wr_i}} & {hit_cfg1, hit_cfg0};
  wire logic [1:0] wr_cnt = {2{reg_wr_i}} & {hit_cnt1, hit_cnt0};
  wire logic wr_sen = reg_wr_i & hit_sen;
  wire logic wr_tsc = reg_wr_i & hit_tsc;

  // Writer-relative bits become absolute thread enables
  wire logic [1:0] sen_written = rel_to_abs(writer_thread,
      reg_wdata_i[`SEN_OWN], reg_wdata_i[`SEN_SIBLING]);

  // ----------------------------------------------------------------------
  // Power gating and clockticks
  // ----------------------------------------------------------------------
  wire logic [1:0] nonhalted_tick;
  wire logic nonsleep_tick;
  wire logic [1:0] reference_tick;
  wire logic tsc_tick;
  wire logic powered_down;

  clocktick_gate u_gate (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .dual_thread_i(dual_thread_i),
    .halted_i(halted_i),
    .power_save_i(power_save_i),
    .package_sleep_i(package_sleep_i),
    .deep_sleep_i(deep_sleep_i),
    .nonhalted_tick_o(nonhalted_tick),
    .nonsleep_tick_o(nonsleep_tick),
    .reference_tick_o(reference_tick),
    .tsc_tick_o(tsc_tick),
    .powered_down_o(powered_down)
  );

  // ----------------------------------------------------------------------
  // Per-counter qualification
  // ----------------------------------------------------------------------
  wire logic [1:0] qualified;
  wire logic [1:0] inc;
  wire logic [1:0] wraps;
  wire logic [1:0] ovf_event;
  wire logic [1:0] sample_fire;
  wire logic precise_class = (event_class_i != CLASS_OTHER);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ctr
      event_qualify u_qual (
        .flags_i(cfg_reg[g][3:0]),
        .t0_priv_i(t0_priv_i),
        .t1_priv_i(t1_priv_i),
        .event_thread_i(event_thread_i),
        .thread_independent_event_i(thread_independent_event_i),
        .qualified_o(qualified[g])
      );

      // Source of one increment for this counter, by mode
      wire logic src_event = event_valid_i & qualified[g];
      wire logic src_tick =
          (is_mode(cfg_reg[g], MODE_NONHALTED) & nonhalted_tick[g]) |
          (is_mode(cfg_reg[g], MODE_NONSLEEP) & nonsleep_tick) |
          (is_mode(cfg_reg[g], MODE_REFERENCE) & reference_tick[g]);
      wire logic src_pick = is_mode(cfg_reg[g], MODE_EVENT) ? src_event : src_tick;

      // Frozen while powered down; a write to this counter takes the cycle
      assign inc[g] = cfg_reg[g][`CFG_ENABLE] & ~powered_down & src_pick & ~wr_cnt[g];
      assign wraps[g] = inc[g] & (&count_reg[g]);
      assign ovf_event[g] = wraps[g] | (inc[g] & cfg_reg[g][`CFG_OVF]);

      // Sampling stays with the counter bound to this thread
      assign sample_fire[g] = wraps[g] & is_mode(cfg_reg[g], MODE_EVENT) &
          sample_en_reg[g] & precise_class & (event_thread_i == 1'(g));
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Overflow flag is sticky; a wrap beats a clearing write
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (reset_i) begin
        cfg_reg[i] <= `CFG_RESET;
      end else begin
        if (wr_cfg[i]) begin
          cfg_reg[i] <= reg_wdata_i & `CFG_WMASK;
        end
        if (wraps[i]) begin
          cfg_reg[i][`CFG_OVF] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Event counters
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (reset_i) begin
        count_reg[i] <= '0;
      end else if (wr_cnt[i]) begin
        count_reg[i] <= reg_wdata_i[`CNT_W-1:0];
      end else if (inc[i]) begin
        count_reg[i] <= count_reg[i] + `CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Time-stamp counter
  // ----------------------------------------------------------------------
  // Keeps running through light halt, stops only in deep sleep
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tsc_reg <= 64'h0000_0000_0000_0000;
    end else if (wr_tsc) begin
      tsc_reg <= reg_wdata_i;
    end else if (tsc_tick) begin
      tsc_reg <= tsc_reg + 64'h0000_0000_0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Precise sampling enable
  // ----------------------------------------------------------------------
  // Held by absolute thread so a later reader sees its own view
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sample_en_reg <= `SEN_RESET;
    end else if (wr_sen) begin
      sample_en_reg <= sen_written;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Enable register reads back relative to the reading thread
  always_comb begin
    rdata_next = 64'h0000_0000_0000_0000;
    fault_next = 1'b0;
    if (hit_cfg0) begin
      rdata_next = cfg_reg[0];
    end else if (hit_cfg1) begin
      rdata_next = cfg_reg[1];
    end else if (hit_sen) begin
      rdata_next[`SEN_OWN] = sample_en_reg[writer_thread];
      rdata_next[`SEN_SIBLING] = sample_en_reg[~writer_thread];
    end else if (hit_cnt0) begin
      rdata_next[`CNT_W-1:0] = count_reg[0];
    end else if (hit_cnt1) begin
      rdata_next[`CNT_W-1:0] = count_reg[1];
    end else if (hit_tsc) begin
      rdata_next = tsc_reg;
    end
    if (!hit_any) begin
      fault_next = 1'b1;
    end
  end

  // Answer registered one cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 64'h0000_0000_0000_0000;
      reg_rvalid_o <= 1'b0;
      reg_fault_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_next : 64'h0000_0000_0000_0000;
      reg_rvalid_o <= reg_rd_i;
      reg_fault_o <= (reg_rd_i | reg_wr_i) & fault_next;
    end
  end

  // ----------------------------------------------------------------------
  // Sample and interrupt requests
  // ----------------------------------------------------------------------
  // Interrupt goes to each thread whose routing bit is set
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      precise_sample_o <= 2'h0;
      overflow_irq_o <= 2'h0;
    end else begin
      precise_sample_o <= sample_fire;
      overflow_irq_o[0] <= (ovf_event[0] & cfg_reg[0][`CFG_PMI_T0]) |
                           (ovf_event[1] & cfg_reg[1][`CFG_PMI_T0]);
      overflow_irq_o[1] <= (ovf_event[0] & cfg_reg[0][`CFG_PMI_T1]) |
                           (ovf_event[1] & cfg_reg[1][`CFG_PMI_T1]);
    end
  end

endmodule : thread_qualified_perf_events

// >>> perf_qual_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the thread-qualified performance event block.
// Assumes: Registers are reached over the model-specific register port.
// Notes:   Offsets are 32-bit register addresses, not byte addresses.
`ifndef PERF_QUAL_REGS_SVH
`define PERF_QUAL_REGS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_T0_CFG 32'h0000_0370
`define ADDR_T1_CFG 32'h0000_0371
`define ADDR_SAMPLE_EN 32'h0000_03A0
`define ADDR_T0_COUNT 32'h0000_03A1
`define ADDR_T1_COUNT 32'h0000_03A2
`define ADDR_TSC 32'h0000_03A3

// ----------------------------------------------------------------------
// Counter configuration fields
// ----------------------------------------------------------------------
`define CFG_THREAD1_USER_QUALIFY 0
`define CFG_THREAD1_KERNEL_QUALIFY 1
`define CFG_THREAD0_USER_QUALIFY 2
`define CFG_THREAD0_KERNEL_QUALIFY 3
`define CFG_ENABLE 12
`define CFG_PMI_T0 26
`define CFG_PMI_T1 27
`define CFG_OVF 31
`define CFG_MODE_LO 32
`define CFG_MODE_HI 33
`define CFG_WMASK 64'h0000_0003_8C00_100F
`define CFG_RESET 64'h0000_0000_0000_0000

// ----------------------------------------------------------------------
// Sample enable fields and timing
// ----------------------------------------------------------------------
`define SEN_OWN 25
`define SEN_SIBLING 26
`define SEN_RESET 2'h0
`define CNT_W 40
`define REF_PERIOD_NS 100
`define CLK_PERIOD_NS 8
`define REF_DIV_CYCLES (`REF_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// >>> perf_qual_pkg.sv
// Purpose: Types shared by the thread-qualified performance event block.
// Assumes: Nothing beyond the register header.
// Notes:   Codes are fixed; counters decode them directly.
package perf_qual_pkg;

  // Counting mode of one counter
  typedef enum logic [1:0] {
    MODE_EVENT = 2'h0,
    MODE_NONHALTED = 2'h1,
    MODE_NONSLEEP = 2'h2,
    MODE_REFERENCE = 2'h3
  } count_mode_t;

  // Event class carried by the event stream
  typedef enum logic [1:0] {
    CLASS_EXECUTION = 2'h0,
    CLASS_FRONT_END = 2'h1,
    CLASS_REPLAY = 2'h2,
    CLASS_OTHER = 2'h3
  } event_class_t;

endpackage : perf_qual_pkg

// >>> event_qualify.sv
// Purpose: Privilege and thread qualification of one event for one counter.
// Assumes: Privilege 0 is kernel, 1 to 3 user.
// Notes:   Purely combinational.
`timescale 1ns/100ps
`include "perf_qual_regs.svh"
module event_qualify import perf_qual_pkg::*; (
  // Qualification flags
  input wire logic [3:0] flags_i,
  // Thread privilege levels
  input wire logic [1:0] t0_priv_i,
  input wire logic [1:0] t1_priv_i,
  // Event attributes
  input wire logic event_thread_i,
  input wire logic thread_independent_event_i,
  // Result
  output logic qualified_o
);

  wire logic t0_user = (t0_priv_i != 2'h0);
  wire logic t1_user = (t1_priv_i != 2'h0);
  wire logic thread0_user_qualify = flags_i[`CFG_THREAD0_USER_QUALIFY];
  wire logic thread0_kernel_qualify = flags_i[`CFG_THREAD0_KERNEL_QUALIFY];
  wire logic thread1_user_qualify = flags_i[`CFG_THREAD1_USER_QUALIFY];
  wire logic thread1_kernel_qualify = flags_i[`CFG_THREAD1_KERNEL_QUALIFY];

  // Specific events look only at the owning thread
  wire logic ts_t0 = (thread0_user_qualify & t0_user) | (thread0_kernel_qualify & ~t0_user);
  wire logic ts_t1 = (thread1_user_qualify & t1_user) | (thread1_kernel_qualify & ~t1_user);
  wire logic ts_hit = event_thread_i ? ts_t1 : ts_t0;

  // Independent events merge both threads' flags
  wire logic usr_any = thread0_user_qualify | thread1_user_qualify;
  wire logic os_any = thread0_kernel_qualify | thread1_kernel_qualify;
  wire logic ti_hit = (usr_any & (t0_user | t1_user)) | (os_any & (~t0_user | ~t1_user));

  assign qualified_o = thread_independent_event_i ? ti_hit : ts_hit;

endmodule : event_qualify

// >>> clocktick_gate.sv
// Purpose: Power-state gating of clocktick counting and reference tick.
// Assumes: Halt and power-save inputs are synchronous to the core clock.
// Notes:   Reference tick is a one-cycle enable from a free divider.
`timescale 1ns/100ps
`include "perf_qual_regs.svh"
module clocktick_gate (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Power state
  input wire logic dual_thread_i,
  input wire logic [1:0] halted_i,
  input wire logic [1:0] power_save_i,
  input wire logic package_sleep_i,
  input wire logic deep_sleep_i,
  // Tick enables
  output logic [1:0] nonhalted_tick_o,
  output logic nonsleep_tick_o,
  output logic [1:0] reference_tick_o,
  output logic tsc_tick_o,
  output logic powered_down_o
);

  localparam logic [7:0] REF_LAST = 8'(`REF_DIV_CYCLES - 1);
  logic [7:0] ref_cnt_reg;
  wire logic ref_pulse = (ref_cnt_reg == REF_LAST);

  // Divider gives one pulse every REF_DIV_CYCLES core clocks, so its rate follows the core clock
  always_ff @(posedge core_clk_i) begin
    if (reset_i || ref_pulse) begin
      ref_cnt_reg <= 8'h00;
    end else begin
      ref_cnt_reg <= ref_cnt_reg + 8'h01;
    end
  end

  // With dual_thread_i one halted thread keeps counters alive; otherwise a halted thread 0 powers them down
  assign powered_down_o = dual_thread_i ? (&halted_i) : halted_i[0];
  assign nonhalted_tick_o = ~halted_i & ~power_save_i;
  assign nonsleep_tick_o = ~package_sleep_i;
  assign reference_tick_o = {2{ref_pulse}} & ~halted_i;
  assign tsc_tick_o = ~deep_sleep_i;

endmodule : clocktick_gate

// >>> perf_events_monitor.sv
// Purpose: Port-level checks for the thread-qualified event block.
// Assumes: One core clock, synchronous active-high reset.
// Notes:   Attached by bind; sees only top-level ports.
`timescale 1ns/100ps
module perf_events_monitor (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [63:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic reg_fault_o,
  // Thread state and events
  input wire logic dual_thread_i,
  input wire logic [1:0] halted_i,
  input wire logic event_valid_i,
  input wire logic event_thread_i,
  input wire logic [1:0] event_class_i,
  // Requests
  input wire logic [1:0] precise_sample_o,
  input wire logic [1:0] overflow_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // Register answers come exactly one cycle after the strobe
  chk_read_answers: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered next cycle");
  chk_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("answer without a read");
  chk_rdata_idle: assert property (!reg_rvalid_o |-> reg_rdata_o == 64'h0)
    else $error("read data outside an answer");
  chk_fault_cause: assert property (reg_fault_o |-> $past(reg_rd_i || reg_wr_i))
    else $error("fault without an access");

  // Sampling needs an allowed class on the counter's own thread
  chk_other_class: assert property (event_valid_i && &event_class_i |=> !precise_sample_o)
    else $error("sample from a class that never samples");
  chk_sample_t0: assert property (precise_sample_o[0] |-> $past(event_valid_i && !event_thread_i))
    else $error("thread 0 sample without thread 0 event");
  chk_sample_t1: assert property (precise_sample_o[1] |-> $past(event_valid_i && event_thread_i))
    else $error("thread 1 sample without thread 1 event");
  chk_idle_quiet: assert property (!event_valid_i |=> !precise_sample_o)
    else $error("sample with no event");

  // Powered-down counters cannot wrap, so no sample follows
  chk_pair_halted: assert property (dual_thread_i && &halted_i |=> !precise_sample_o)
    else $error("sample while both threads halted");
  chk_single_halted: assert property (!dual_thread_i && halted_i[0] |=> !precise_sample_o)
    else $error("sample while lone thread halted");

  // Main scenarios reached
  cov_fault: cover property (reg_fault_o);
  cov_sample: cover property (precise_sample_o[1]);
  cov_irq: cover property (overflow_irq_o[1]);
endmodule : perf_events_monitor

bind thread_qualified_perf_events perf_events_monitor u_perf_events_monitor (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .reg_fault_o(reg_fault_o),
  .dual_thread_i(dual_thread_i), .halted_i(halted_i), .event_valid_i(event_valid_i),
  .event_thread_i(event_thread_i), .event_class_i(event_class_i),
  .precise_sample_o(precise_sample_o), .overflow_irq_o(overflow_irq_o)
);

// >>> thread_pair_model.sv
// Purpose: Two logical processors feeding thread state and events.
// Assumes: Bench calls its tasks after reset.
// Notes:   Released event lines turn over, never keep the last value.
`timescale 1ns/100ps
module thread_pair_model (
  // Clock
  input wire logic core_clk_i,
  // Thread state
  output logic [1:0] t0_priv_o,
  output logic [1:0] t1_priv_o,
  output logic [1:0] halted_o,
  output logic [1:0] power_save_o,
  // Event stream
  output logic event_valid_o,
  output logic event_thread_o,
  output logic event_ti_o,
  output logic [1:0] event_class_o
);
  // Both threads running at kernel level after power-up
  initial begin
    {t0_priv_o, t1_priv_o, halted_o, power_save_o} = 8'h00;
    {event_valid_o, event_thread_o, event_ti_o, event_class_o} = 5'h00;
  end

  // New privilege and power state, launched just after an edge
  task automatic set_state(input logic [1:0] p0, p1, h, ps);
    @(posedge core_clk_i);
    t0_priv_o <= p0;
    t1_priv_o <= p1;
    halted_o <= h;
    power_save_o <= ps;
  endtask : set_state

  // One occurrence, held for exactly one cycle
  task automatic fire(input logic thr, ti, input logic [1:0] cls);
    @(posedge core_clk_i);
    event_valid_o <= 1'b1;
    event_thread_o <= thr;
    event_ti_o <= ti;
    event_class_o <= cls;
    @(posedge core_clk_i);
    event_valid_o <= 1'b0;
    // Stale attributes would hide a design that ignores valid
    {event_thread_o, event_ti_o, event_class_o} <= ~{thr, ti, cls};
  endtask : fire
endmodule : thread_pair_model

// >>> thread_qualified_perf_events_tb_top.sv
// Purpose: Self-checking bench for the thread-qualified event block.
// Assumes: Partner model supplies thread state and events.
// Notes:   Expected counts come from a reference model of the rules.
`timescale 1ns/100ps
`include "perf_qual_regs.svh"
module thread_qualified_perf_events_tb_top import perf_qual_pkg::*;
;
  // Bench-driven inputs
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_addr_i = 32'h0;
  logic [63:0] reg_wdata_i = 64'h0;
  logic [7:0] reg_initial_id_i = 8'h0;
  logic dual_thread_i = 1'b1;
  logic package_sleep_i = 1'b0;
  logic deep_sleep_i = 1'b0;
  // Partner and design outputs
  wire logic [1:0] t0_priv, t1_priv, halted, power_save, ev_class;
  wire logic ev_valid, ev_thread, ev_ti, reg_rvalid_o, reg_fault_o;
  wire logic [63:0] reg_rdata_o;
  wire logic [1:0] precise_sample_o, overflow_irq_o;
  // Bookkeeping
  integer num_errors = 0;
  integer checked = 0;
  integer cycles = 0;
  integer samp_n [2] = '{0, 0};
  integer irq_n [2] = '{0, 0};
  logic [15:0] lfsr_state = 16'hAD83;
  logic [63:0] rd_data;
  logic rd_fault;

  always #4 core_clk_i = ~core_clk_i;

  thread_pair_model u_thread_pair_model (.core_clk_i(core_clk_i), .t0_priv_o(t0_priv),
    .t1_priv_o(t1_priv), .halted_o(halted), .power_save_o(power_save), .event_valid_o(ev_valid),
    .event_thread_o(ev_thread), .event_ti_o(ev_ti), .event_class_o(ev_class));

  thread_qualified_perf_events u_thread_qualified_perf_events (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_initial_id_i(reg_initial_id_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .reg_fault_o(reg_fault_o), .dual_thread_i(dual_thread_i),
    .t0_priv_i(t0_priv), .t1_priv_i(t1_priv), .halted_i(halted), .power_save_i(power_save),
    .package_sleep_i(package_sleep_i), .deep_sleep_i(deep_sleep_i), .event_valid_i(ev_valid),
    .event_thread_i(ev_thread), .thread_independent_event_i(ev_ti), .event_class_i(ev_class),
    .precise_sample_o(precise_sample_o), .overflow_irq_o(overflow_irq_o));

  // Pulse tallies; an unknown pulse poisons the tally so it never matches
  always @(posedge core_clk_i) begin
    samp_n[0] <= samp_n[0] + precise_sample_o[0];
    samp_n[1] <= samp_n[1] + precise_sample_o[1];
    irq_n[0] <= irq_n[0] + overflow_irq_o[0];
    irq_n[1] <= irq_n[1] + overflow_irq_o[1];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Reference qualification; flags 0 T1 user, 1 T1 kernel, 2 T0 user, 3 T0 kernel
  function automatic integer qual(input logic [3:0] f, input logic [1:0] p0, p1,
    input logic thr, ti);
    if (ti) begin
      return ((f[2] | f[0]) && (p0 != 2'h0 || p1 != 2'h0)) ||
        ((f[3] | f[1]) && (p0 == 2'h0 || p1 == 2'h0));
    end
    if (thr) begin
      return (f[0] && p1 != 2'h0) || (f[1] && p1 == 2'h0);
    end
    return (f[2] && p0 != 2'h0) || (f[3] && p0 == 2'h0);
  endfunction : qual

  // One register access; identity bit 0 names the thread, upper bits random
  task automatic reg_access(input logic wr, input logic [31:0] a, input logic [63:0] d,
    input logic thr, output logic [63:0] rdata, output logic fault);
    @(posedge core_clk_i);
    lfsr_state = lfsr_next(lfsr_state);
    reg_wr_i <= wr;
    reg_rd_i <= !wr;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_initial_id_i <= {lfsr_state[7:1], thr};
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
    rdata = reg_rdata_o;
    fault = reg_fault_o;
  endtask : reg_access

  task automatic wr(input logic [31:0] a, input logic [63:0] d);
    reg_access(1'b1, a, d, 1'b0, rd_data, rd_fault);
  endtask : wr

  task automatic rd_check(input logic [31:0] a, input logic thr, input logic [63:0] exp);
    reg_access(1'b0, a, 64'h0, thr, rd_data, rd_fault);
    check(rd_data, exp);
  endtask : rd_check

  initial begin : main
    integer f;
    integer k;
    integer e0;
    integer e1;
    integer s0;
    integer q0;
    logic [1:0] p0;
    logic [1:0] p1;
    logic pd;
    logic [15:0] r;
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    // Reset values, unmapped place, configuration write mask
    rd_check(`ADDR_T0_CFG, 1'b0, `CFG_RESET);
    rd_check(`ADDR_SAMPLE_EN, 1'b1, 64'h0);
    reg_access(1'b0, 32'h0000_03B0, 64'h0, 1'b0, rd_data, rd_fault);
    check({63'h0, rd_fault}, 64'h1);
    wr(`ADDR_T1_CFG, {64{1'b1}});
    rd_check(`ADDR_T1_CFG, 1'b1, `CFG_WMASK);
    // Every flag set against kernel and user privilege, each thread and event kind
    e0 = 0;
    for (f = 0; f < 16; f++) begin
      for (k = 0; k < 2; k++) wr(`ADDR_T0_CFG + 32'(k), 64'h1000 | 64'(f));
      for (k = 0; k < 2; k++) wr(`ADDR_T0_COUNT + 32'(k), 64'h0);
      e0 = 0;
      for (k = 0; k < 16; k++) begin
        lfsr_state = lfsr_next(lfsr_state);
        p0 = k[0] ? {lfsr_state[1], 1'b1} : 2'h0;
        p1 = k[1] ? {lfsr_state[2], 1'b1} : 2'h0;
        u_thread_pair_model.set_state(p0, p1, 2'b00, lfsr_state[5:4]);
        u_thread_pair_model.fire(k[2], k[3], lfsr_state[7:6]);
        e0 = e0 + qual(f[3:0], p0, p1, k[2], k[3]);
        rd_check(`ADDR_T0_COUNT, k[2], 64'(e0));
        rd_check(`ADDR_T1_COUNT, k[3], 64'(e0));
      end
    end
    // Thread 1 enables its own sampling; view depends on the reader
    reg_access(1'b1, `ADDR_SAMPLE_EN, 64'h1 << `SEN_OWN, 1'b1, rd_data, rd_fault);
    rd_check(`ADDR_SAMPLE_EN, 1'b1, 64'h1 << `SEN_OWN);
    rd_check(`ADDR_SAMPLE_EN, 1'b0, 64'h1 << `SEN_SIBLING);
    u_thread_pair_model.set_state(2'h0, 2'h3, 2'b00, 2'b00);
    for (k = 0; k < 4; k++) begin
      // Routing alternates so both interrupt lines are exercised
      wr(`ADDR_T1_CFG, 64'h1001 | (64'h1 << (`CFG_PMI_T0 + k % 2)));
      wr(`ADDR_T1_COUNT, 64'hFF_FFFF_FFFF);
      e0 = samp_n[1];
      s0 = samp_n[0];
      e1 = irq_n[k % 2];
      q0 = irq_n[1 - k % 2];
      u_thread_pair_model.fire(1'b1, 1'b0, 2'(k));
      repeat (2) @(posedge core_clk_i);
      #1;
      check(64'(samp_n[1] - e0), 64'(k != 3));
      check(64'(samp_n[0] - s0), 64'h0);
      check(64'(irq_n[k % 2] - e1), 64'h1);
      check(64'(irq_n[1 - k % 2] - q0), 64'h0);
      rd_check(`ADDR_T1_CFG, 1'b1, 64'h8000_1001 | (64'h1 << (`CFG_PMI_T0 + k % 2)));
      rd_check(`ADDR_T1_COUNT, 1'b0, 64'h0);
    end
    // Clocktick modes over random power states, 24-cycle windows
    u_thread_pair_model.set_state(2'h0, 2'h0, 2'b11, 2'b00);
    deep_sleep_i <= 1'b1;
    for (k = 0; k < 12; k++) begin
      wr(`ADDR_T0_CFG, {30'h0, MODE_NONHALTED, 32'h0000_1000});
      wr(`ADDR_T1_CFG, {30'h0, k[0] ? MODE_NONSLEEP : MODE_REFERENCE, 32'h0000_1000});
      for (f = 0; f < 3; f++) wr(`ADDR_T0_COUNT + 32'(f), 64'h0);
      lfsr_state = lfsr_next(lfsr_state);
      r = lfsr_state;
      u_thread_pair_model.set_state(2'h0, 2'h0, r[4:3], r[6:5]);
      dual_thread_i <= r[0];
      package_sleep_i <= r[1];
      deep_sleep_i <= r[2];
      repeat (23) @(posedge core_clk_i);
      u_thread_pair_model.set_state(2'h0, 2'h0, 2'b11, 2'b00);
      dual_thread_i <= 1'b1;
      deep_sleep_i <= 1'b1;
      pd = r[0] ? (r[4] & r[3]) : r[3];
      rd_check(`ADDR_T0_COUNT, 1'b0, (pd || r[3] || r[5]) ? 64'h0 : 64'h18);
      rd_check(`ADDR_T1_COUNT, 1'b1, pd ? 64'h0 : k[0] ? (r[1] ? 64'h0 : 64'h18) :
        (r[4] ? 64'h0 : 64'h2));
      rd_check(`ADDR_TSC, 1'b0, r[2] ? 64'h0 : 64'h18);
    end
    finish_test();
  end
endmodule : thread_qualified_perf_events_tb_top
